/* File: crs_alu.sv */
`include "crs_params.svh"

module crs_alu (
    input  wire crs_pkg::crs_op_t i_op,
    input  wire logic [7:0]       i_a,
    input  wire logic [7:0]       i_opnd,
    input  wire logic             i_c,
    input  wire logic             i_bit,
    output crs_pkg::crs_alu_t     o_res
);

    logic [8:0] sum;
    logic [4:0] nib;
    logic       cin;

    always_comb
    begin
        o_res = '0;
        sum   = '0;
        nib   = '0;
        cin   = (i_op == crs_pkg::OP_ADC) && i_c;
        o_res.res = i_a;
        case (i_op)
            crs_pkg::OP_LDA:
            begin
                o_res.res  = i_opnd;
                o_res.wr_a = 1'b1;
            end
            crs_pkg::OP_LDX:
            begin
                o_res.res  = i_opnd;
                o_res.wr_x = 1'b1;
            end
            crs_pkg::OP_ADD, crs_pkg::OP_ADC:
            begin
                sum = {1'b0, i_a} + {1'b0, i_opnd} + {8'h00, cin};
                nib = {1'b0, i_a[3:0]} + {1'b0, i_opnd[3:0]} + {4'h0, cin};
                o_res.res  = sum[7:0];
                o_res.wr_a = 1'b1;
                o_res.wr_h = 1'b1;
                o_res.h    = nib[4];
                o_res.wr_c = 1'b1;
                o_res.c    = sum[8];
            end
            crs_pkg::OP_SUB:
            begin
                sum = {1'b0, i_a} - {1'b0, i_opnd};
                o_res.res  = sum[7:0];
                o_res.wr_a = 1'b1;
                o_res.wr_c = 1'b1;
                o_res.c    = sum[8];
            end
            crs_pkg::OP_AND:
            begin
                o_res.res  = i_a & i_opnd;
                o_res.wr_a = 1'b1;
            end
            crs_pkg::OP_ORA:
            begin
                o_res.res  = i_a | i_opnd;
                o_res.wr_a = 1'b1;
            end
            crs_pkg::OP_EOR:
            begin
                o_res.res  = i_a ^ i_opnd;
                o_res.wr_a = 1'b1;
            end
            // carry is left alone here on purpose
            crs_pkg::OP_INC:
            begin
                o_res.res  = i_a + 8'h01;
                o_res.wr_a = 1'b1;
            end
            crs_pkg::OP_MINUS_ONE:
            begin
                o_res.res  = i_a - 8'h01;
                o_res.wr_a = 1'b1;
            end
            crs_pkg::OP_LSL, crs_pkg::OP_ROL:
            begin
                o_res.res  = {i_a[6:0], (i_op == crs_pkg::OP_ROL) && i_c};
                o_res.wr_a = 1'b1;
                o_res.wr_c = 1'b1;
                o_res.c    = i_a[7];
            end
            crs_pkg::OP_LSR, crs_pkg::OP_ROR:
            begin
                o_res.res  = {(i_op == crs_pkg::OP_ROR) && i_c, i_a[7:1]};
                o_res.wr_a = 1'b1;
                o_res.wr_c = 1'b1;
                o_res.c    = i_a[0];
            end
            crs_pkg::OP_BTST:
            begin
                o_res.wr_c = 1'b1;
                o_res.c    = i_bit;
            end
            default:
            begin
                o_res.res = i_a;
            end
        endcase
        o_res.wr_n = o_res.wr_a || o_res.wr_x;
        o_res.wr_z = o_res.wr_n;
        o_res.n    = o_res.res[7];
        o_res.z    = (o_res.res == 8'h00);
    end

endmodule : crs_alu

/* File: crs_core.sv */
// Behaviour
// - six-bit stack pointer, 64 bytes, wraps from bottom back to top
// - any reset or reset-stack-pointer op loads the top-of-stack value
// - pointer names next free byte; post-decrement push, pre-increment pull
// - stack address is fixed upper bits joined to the six pointer bits
// - call pushes two bytes, interrupt entry pushes five
// - accumulator and index survive pin and internal reset untouched; power-up reset clears them
// - indexed address: index alone, or index plus 8- or 16-bit offset
// - pc steps after each fetch; jumps and entries load a target
// - five flags, upper three read as ones, pin and internal reset touch only the mask
// - half carry from nibble carry on add and add-with-carry
// - mask set after context push, before vector fetch
// - masked requests stay pending until the mask clears
// - handler return pulls full context, restores mask, resumes
// - reset sets the mask; clear-mask or wait clears it, a handler return restores it
// - negative copies result bit seven, loads included
// - zero set when result is zero, cleared otherwise
// - carry from adds, subtract, bit test, shifts, rotates; never inc or dec
// - interrupts wait for op completion; reset acts at once
// - take only unmasked enabled sources; highest vector wins
// - vector table at top: reset, trap, external, mft, 16-bit timer
// - trap ignores the mask, unmasked pending interrupts go first, own vector
// - reset pin low or internal reset sets mask, fetches reset vector
`include "crs_params.svh"

module crs_core #(
    parameter int SP_BITS = `CRS_SP_BITS
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic              i_rst_pin_n,
    input  wire logic              i_int_rst,
    input  wire logic              i_op_valid,
    input  wire crs_pkg::crs_op_t  i_op,
    input  wire logic [7:0]        i_operand,
    input  wire logic              i_bit,
    input  wire logic [15:0]       i_target,
    input  wire crs_pkg::crs_idx_t i_idx_mode,
    input  wire logic [15:0]       i_offset,
    input  wire logic [2:0]        i_irq_req,
    input  wire logic [2:0]        i_irq_en,
    input  wire logic [7:0]        i_mem_rdata,
    output logic                   o_ready,
    output logic                   o_done,
    output logic [7:0]             o_acc,
    output logic [7:0]             o_idx,
    output logic [5:0]             o_sp,
    output logic [15:0]            o_pc,
    output crs_pkg::crs_cc_t       o_flags,
    output logic [15:0]            o_ea,
    output logic [15:0]            o_mem_addr,
    output logic [7:0]             o_mem_wdata,
    output logic                   o_mem_we,
    output logic                   o_mem_rd,
    output logic [2:0]             o_irq_ack
);

    if (SP_BITS != 6)
    begin : g_chk
        $error("crs_core: stack pointer logic serves six bits only");
    end

    crs_pkg::crs_core_t r_reg;
    crs_pkg::crs_core_t r_next;
    crs_pkg::crs_alu_t  alu;

    crs_alu u_alu (
        .i_op   (i_op),
        .i_a    (r_reg.a),
        .i_opnd (i_operand),
        .i_c    (r_reg.cc.c),
        .i_bit  (i_bit),
        .o_res  (alu)
    );

    function automatic logic [15:0] stk_addr(input logic [5:0] sp);
        stk_addr = {`CRS_SP_UPPER, sp};
    endfunction : stk_addr

    // lowest index carries the highest vector
    function automatic logic [2:0] pick_src(input logic [2:0] p);
        if (p[0])
            pick_src = 3'h1;
        else if (p[1])
            pick_src = 3'h2;
        else if (p[2])
            pick_src = 3'h4;
        else
            pick_src = 3'h0;
    endfunction : pick_src

    function automatic logic [15:0] src_vec(input logic [2:0] s);
        if (s[0])
            src_vec = `CRS_VEC_EXT;
        else if (s[1])
            src_vec = `CRS_VEC_MFT;
        else
            src_vec = `CRS_VEC_T16;
    endfunction : src_vec

    function automatic logic [15:0] idx_addr(
        input crs_pkg::crs_idx_t m,
        input logic [7:0]        x,
        input logic [15:0]       off
    );
        case (m)
            crs_pkg::IDX_OFF8:  idx_addr = {8'h00, x} + {8'h00, off[7:0]};
            crs_pkg::IDX_OFF16: idx_addr = {8'h00, x} + off;
            default:            idx_addr = {8'h00, x};
        endcase
    endfunction : idx_addr

    // push index: 0 pcl, 1 pch, 2 index, 3 acc, 4 flags
    function automatic logic [7:0] ctx_byte(
        input logic [2:0]       k,
        input logic [15:0]      pc,
        input logic [7:0]       x,
        input logic [7:0]       a,
        input crs_pkg::crs_cc_t cc
    );
        case (k)
            3'h0:    ctx_byte = pc[7:0];
            3'h1:    ctx_byte = pc[15:8];
            3'h2:    ctx_byte = x;
            3'h3:    ctx_byte = a;
            default: ctx_byte = {`CRS_CC_UPPER, cc};
        endcase
    endfunction : ctx_byte

    logic [2:0] pend;
    logic       take;
    logic       dev_rst;
    logic [2:0] nbytes;
    logic [2:0] pidx;
    logic [2:0] sel;

    always_comb
    begin
        r_next = r_reg;
        r_next.mwe  = 1'b0;
        r_next.mrd  = 1'b0;
        r_next.done = 1'b0;
        r_next.ack  = 3'h0;
        r_next.rsync = {r_reg.rsync[0], i_rst_pin_n};
        pend    = i_irq_req & i_irq_en;
        // a level request is simply held while the mask is set
        take    = !r_reg.cc.i && (pend != 3'h0);
        dev_rst = i_rst || i_int_rst || !r_reg.rsync[1];
        nbytes  = `CRS_INT_BYTES;
        pidx    = 3'h0;
        sel     = 3'h0;
        case (r_reg.fsm)
            crs_pkg::ST_RUN:
            begin
                // only sampled at an op boundary, never mid-op
                if (r_reg.ready && take)
                begin
                    r_next.fsm    = crs_pkg::ST_PUSH;
                    r_next.kind   = crs_pkg::K_INT;
                    r_next.cnt    = 3'h0;
                    r_next.srcsel = pick_src(pend);
                end
                else if (r_reg.ready && i_op_valid)
                begin
                    r_next.done = 1'b1;
                    r_next.ea   = idx_addr(i_idx_mode, r_reg.x,
                                           i_offset);
                    if (alu.wr_a)
                        r_next.a = alu.res;
                    if (alu.wr_x)
                        r_next.x = alu.res;
                    if (alu.wr_h)
                        r_next.cc.h = alu.h;
                    if (alu.wr_n)
                        r_next.cc.n = alu.n;
                    if (alu.wr_z)
                        r_next.cc.z = alu.z;
                    if (alu.wr_c)
                        r_next.cc.c = alu.c;
                    case (i_op)
                        crs_pkg::OP_FETCH:
                            r_next.pc = r_reg.pc + 16'h0001;
                        crs_pkg::OP_JMP:
                            r_next.pc = i_target;
                        crs_pkg::OP_CLEAR_MASK:
                            r_next.cc.i = 1'b0;
                        crs_pkg::OP_SET_MASK:
                            r_next.cc.i = 1'b1;
                        crs_pkg::OP_CLC:
                            r_next.cc.c = 1'b0;
                        crs_pkg::OP_SEC:
                            r_next.cc.c = 1'b1;
                        crs_pkg::OP_RESET_SP:
                            r_next.sp = `CRS_SP_RST;
                        crs_pkg::OP_JSR:
                        begin
                            r_next.tgt  = i_target;
                            r_next.kind = crs_pkg::K_JSR;
                            r_next.fsm  = crs_pkg::ST_PUSH;
                            r_next.cnt  = 3'h0;
                        end
                        crs_pkg::OP_RTS:
                        begin
                            r_next.kind = crs_pkg::K_RTS;
                            r_next.fsm  = crs_pkg::ST_PULL;
                            r_next.cnt  = 3'h0;
                        end
                        crs_pkg::OP_RETURN_HANDLER:
                        begin
                            r_next.kind = crs_pkg::K_RTI;
                            r_next.fsm  = crs_pkg::ST_PULL;
                            r_next.cnt  = 3'h0;
                        end
                        crs_pkg::OP_SOFTWARE_TRAP:
                        begin
                            // no mask check: the mask never holds the trap off
                            r_next.kind = crs_pkg::K_TRAP;
                            r_next.fsm  = crs_pkg::ST_PUSH;
                            r_next.cnt  = 3'h0;
                        end
                        crs_pkg::OP_WAIT:
                        begin
                            r_next.cc.i = 1'b0;
                            r_next.fsm  = crs_pkg::ST_WAIT;
                        end
                        default:
                            r_next.cnt = r_reg.cnt;
                    endcase
                end
            end
            crs_pkg::ST_WAIT:
            begin
                if (take)
                begin
                    r_next.fsm    = crs_pkg::ST_PUSH;
                    r_next.kind   = crs_pkg::K_INT;
                    r_next.cnt    = 3'h0;
                    r_next.srcsel = pick_src(pend);
                end
            end
            crs_pkg::ST_PUSH:
            begin
                if (r_reg.kind == crs_pkg::K_JSR)
                    nbytes = `CRS_CALL_BYTES;
                else
                    nbytes = `CRS_INT_BYTES;
                r_next.mwe    = 1'b1;
                r_next.maddr  = stk_addr(r_reg.sp);
                r_next.mwdata = ctx_byte(r_reg.cnt, r_reg.pc, r_reg.x,
                                         r_reg.a, r_reg.cc);
                // six-bit arithmetic wraps the bottom back to the top
                r_next.sp  = r_reg.sp - 6'h01;
                r_next.cnt = r_reg.cnt + 3'h1;
                if (r_reg.cnt == 3'(nbytes - 3'h1))
                begin
                    r_next.cnt = 3'h0;
                    if (r_reg.kind == crs_pkg::K_JSR)
                    begin
                        r_next.pc  = r_reg.tgt;
                        r_next.fsm = crs_pkg::ST_RUN;
                    end
                    else
                    begin
                        r_next.cc.i = 1'b1;
                        r_next.fsm  = crs_pkg::ST_VEC;
                        if (r_reg.kind == crs_pkg::K_TRAP)
                            r_next.vec = `CRS_VEC_TRAP;
                        else
                        begin
                            // re-arbitrate after stacking; keep the
                            // entry source if no request remains
                            sel = pick_src(pend);
                            if (sel == 3'h0)
                                sel = r_reg.srcsel;
                            r_next.srcsel = sel;
                            r_next.vec    = src_vec(sel);
                            r_next.ack    = sel;
                        end
                    end
                end
            end
            crs_pkg::ST_VEC:
            begin
                r_next.cnt = r_reg.cnt + 3'h1;
                case (r_reg.cnt)
                    3'h0:
                    begin
                        r_next.mrd   = 1'b1;
                        r_next.maddr = r_reg.vec;
                    end
                    3'h1:
                    begin
                        r_next.mrd   = 1'b1;
                        r_next.maddr = r_reg.vec + 16'h0001;
                    end
                    3'h2:
                        r_next.pc[15:8] = i_mem_rdata;
                    default:
                    begin
                        r_next.pc[7:0] = i_mem_rdata;
                        r_next.cnt     = 3'h0;
                        r_next.fsm     = crs_pkg::ST_RUN;
                    end
                endcase
            end
            crs_pkg::ST_PULL:
            begin
                if (r_reg.kind == crs_pkg::K_RTI)
                    nbytes = `CRS_INT_BYTES;
                else
                    nbytes = `CRS_CALL_BYTES;
                r_next.cnt = r_reg.cnt + 3'h1;
                if (r_reg.cnt < nbytes)
                begin
                    r_next.sp    = r_reg.sp + 6'h01;
                    r_next.mrd   = 1'b1;
                    r_next.maddr = stk_addr(r_reg.sp + 6'h01);
                end
                if (r_reg.cnt >= 3'h2)
                begin
                    pidx = 3'(nbytes - 3'h1 - (r_reg.cnt - 3'h2));
                    case (pidx)
                        3'h0: r_next.pc[7:0]  = i_mem_rdata;
                        3'h1: r_next.pc[15:8] = i_mem_rdata;
                        3'h2: r_next.x        = i_mem_rdata;
                        3'h3: r_next.a        = i_mem_rdata;
                        default: r_next.cc    = i_mem_rdata[4:0];
                    endcase
                end
                if (r_reg.cnt == 3'(nbytes + 3'h1))
                begin
                    r_next.cnt = 3'h0;
                    r_next.fsm = crs_pkg::ST_RUN;
                end
            end
            default:
                r_next.fsm = crs_pkg::ST_RUN;
        endcase
        if (i_rst)
        begin
            // power-up only: gives data registers a known value once
            r_next       = '0;
            r_next.rsync = 2'h3;
        end
        if (dev_rst)
        begin
            // acc and index are deliberately left alone here
            r_next.fsm    = crs_pkg::ST_VEC;
            r_next.kind   = crs_pkg::K_RST;
            r_next.cnt    = 3'h0;
            r_next.sp     = `CRS_SP_RST;
            r_next.cc.i   = 1'b1;
            r_next.vec    = `CRS_VEC_RST;
            r_next.mwe    = 1'b0;
            r_next.mrd    = 1'b0;
            r_next.done   = 1'b0;
            r_next.ack    = 3'h0;
            r_next.srcsel = 3'h0;
        end
        r_next.ready = (r_next.fsm == crs_pkg::ST_RUN) && !dev_rst;
    end

    always_ff @(posedge i_mclk)
    begin
        r_reg <= r_next;
    end

    assign o_ready     = r_reg.ready;
    assign o_done      = r_reg.done;
    assign o_acc       = r_reg.a;
    assign o_idx       = r_reg.x;
    assign o_sp        = r_reg.sp;
    assign o_pc        = r_reg.pc;
    assign o_flags     = r_reg.cc;
    assign o_ea        = r_reg.ea;
    assign o_mem_addr  = r_reg.maddr;
    assign o_mem_wdata = r_reg.mwdata;
    assign o_mem_we    = r_reg.mwe;
    assign o_mem_rd    = r_reg.mrd;
    assign o_irq_ack   = r_reg.ack;

endmodule : crs_core

/* File: crs_core_props.sv */
module crs_core_props (
    input wire logic             i_mclk,
    input wire logic             i_rst,
    input wire logic             i_op_valid,
    input wire logic             o_ready,
    input wire logic [5:0]       o_sp,
    input wire crs_pkg::crs_cc_t o_flags,
    input wire logic [15:0]      o_mem_addr,
    input wire logic             o_mem_we,
    input wire logic             o_mem_rd,
    input wire logic [2:0]       o_irq_ack
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    stack_page_a: assert property (o_mem_we |->
        o_mem_addr[15:6] == 10'h003)
        else $error("stack write off page");
    push_start_a: assert property ($rose(o_mem_we) |->
        o_mem_addr[5:0] == $past(o_sp))
        else $error("push not at free slot");
    reset_state_a: assert property ($fell(i_rst) |->
        o_flags.i && o_sp == 6'h3f)
        else $error("reset state wrong");
    reset_vec_a: assert property ($fell(i_rst) |->
        ##[1:3] (o_mem_rd && o_mem_addr == 16'h0ffe))
        else $error("no reset vector fetch");
    ack_mask_a: assert property (|o_irq_ack |->
        $onehot(o_irq_ack) && o_flags.i)
        else $error("ack with mask clear");
    // the ack rides on the last push byte; the vector read follows it
    ack_vec_a: assert property (|o_irq_ack |=> o_mem_rd &&
        o_mem_addr == ($past(o_irq_ack[0]) ? 16'h0ffa :
        $past(o_irq_ack[1]) ? 16'h0ff8 : 16'h0ff6))
        else $error("wrong vector");
    push_five_a: assert property (|o_irq_ack |->
        o_mem_we && $past(o_mem_we, 4))
        else $error("context not pushed");
    masked_idle_a: assert property (o_ready && o_flags.i &&
        !i_op_valid |=> !o_mem_we)
        else $error("masked request taken");
endmodule : crs_core_props

bind crs_core crs_core_props p_u (.*);

/* File: crs_core_test.sv */
module crs_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk, i_rst, i_rst_pin_n, i_int_rst, i_op_valid, i_bit;
    logic o_ready, o_done, o_mem_we, o_mem_rd, c;
    crs_pkg::crs_op_t  i_op;
    crs_pkg::crs_idx_t i_idx_mode;
    crs_pkg::crs_cc_t  o_flags;
    logic [7:0]  i_operand, i_mem_rdata, o_acc, o_idx, o_mem_wdata, a, x;
    logic [15:0] i_target, i_offset, o_pc, o_ea, o_mem_addr;
    logic [2:0]  i_irq_req, i_irq_en, o_irq_ack;
    logic [5:0]  o_sp;
    logic [9:0]  e;
    logic [31:0] seed = 32'h10;
    int          n_errors, checked, cyc;
    crs_core dut_u (.*);
    crs_mem_model mem_u (.i_mclk(i_mclk), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
        .i_we(o_mem_we), .i_rd(o_mem_rd), .o_rdata(i_mem_rdata));
    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    function automatic logic [9:0] addx(input logic [7:0] a, b, input logic ci);
        logic [4:0] lo;
        lo = a[3:0] + b[3:0] + ci;
        return {lo[4], {1'b0, a} + b + ci};
    endfunction : addx
    function automatic logic [15:0] ea_exp(input int m, input logic [7:0] v,
                                           input logic [15:0] o);
        return {8'h00, v} + (m == 2 ? o : m == 1 ? {8'h00, o[7:0]} : 16'h0);
    endfunction : ea_exp
    task automatic chk(input string s, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic idle();
        while (o_ready !== 1'b1)
            @(negedge i_mclk);
    endtask : idle
    task automatic run(input crs_pkg::crs_op_t op, input logic [7:0] d);
        @(negedge i_mclk);
        seed = xs(seed);
        i_op = op;
        {i_operand, i_offset, i_op_valid} = {d, seed[15:0], 1'b1};
        idle();
        @(negedge i_mclk);
        i_op_valid = 1'b0;
    endtask : run
    task automatic tally_and_finish();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        {i_rst, i_rst_pin_n, i_int_rst, i_op_valid, i_bit} = 5'b11000;
        i_op = crs_pkg::OP_NOP;
        {i_operand, i_offset} = {8'h00, 16'h0000};
        {i_target, i_irq_req, i_irq_en} = {16'h0345, 3'h0, 3'h7};
        i_idx_mode = crs_pkg::IDX_OFF16;
        repeat (8) @(negedge i_mclk);
        i_rst = 1'b0;
        repeat (8) @(negedge i_mclk);
        chk("mask", o_flags.i, 1'b1);
        chk("pc", o_pc, 16'hfeff);
        for (int k = 0; k < 24; k++)
        begin
            seed = xs(seed);
            {x, a} = seed[31:16];
            i_idx_mode = crs_pkg::crs_idx_t'(2'(k % 3));
            run(crs_pkg::OP_LDX, x);
            run(crs_pkg::OP_LDA, a);
            chk("n", o_flags.n, a[7]);
            e = addx(a, seed[15:8], k[0] & c);
            run(k[0] ? crs_pkg::OP_ADC : crs_pkg::OP_ADD, seed[15:8]);
            chk("ea", o_ea, ea_exp(k % 3, x, i_offset));
            chk("acc", o_acc, e[7:0]);
            chk("c", o_flags.c, e[8]);
            chk("h", o_flags.h, e[9]);
            chk("z", o_flags.z, e[7:0] == 8'h00);
            c = e[8];
            run(k[1] ? crs_pkg::OP_MINUS_ONE : crs_pkg::OP_INC, 8'h00);
            chk("c", o_flags.c, c);
        end
        i_bit = !c;
        run(crs_pkg::OP_BTST, 8'h00);
        chk("c", o_flags.c, !c);
        run(crs_pkg::OP_FETCH, 8'h00);
        chk("pc", o_pc, 16'hff00);
        i_irq_req = 3'h6;
        run(crs_pkg::OP_NOP, 8'h00);
        run(crs_pkg::OP_CLEAR_MASK, 8'h00);
        chk("mask", o_flags.i, 1'b0);
        while (o_irq_ack === 3'h0)
            @(negedge i_mclk);
        chk("ack", o_irq_ack, 3'h2);
        i_irq_req = 3'h0;
        idle();
        chk("pc", o_pc, 16'hf8f9);
        chk("sp", o_sp, 6'h3a);
        run(crs_pkg::OP_RETURN_HANDLER, 8'h00);
        idle();
        chk("mask", o_flags.i, 1'b0);
        chk("pc", o_pc, 16'hff00);
        run(crs_pkg::OP_SOFTWARE_TRAP, 8'h00);
        idle();
        chk("pc", o_pc, 16'hfcfd);
        run(crs_pkg::OP_RESET_SP, 8'h00);
        chk("sp", o_sp, 6'h3f);
        run(crs_pkg::OP_JSR, 8'h00);
        run(crs_pkg::OP_RTS, 8'h00);
        idle();
        chk("pc", o_pc, 16'hfcfd);
        repeat (33)
            run(crs_pkg::OP_JSR, 8'h00);
        idle();
        chk("sp", o_sp, 6'h3d);
        chk("pc", o_pc, 16'h0345);
        run(crs_pkg::OP_WAIT, 8'h00);
        chk("mask", o_flags.i, 1'b0);
        // pin reset in mid-run: data registers must come through it
        i_rst_pin_n = 1'b0;
        repeat (4) @(negedge i_mclk);
        i_rst_pin_n = 1'b1;
        idle();
        chk("acc", o_acc, 8'(e[7:0] - 8'h01));
        chk("idx", o_idx, x);
        chk("sp", o_sp, 6'h3f);
        chk("pc", o_pc, 16'hfeff);
        chk("mask", o_flags.i, 1'b1);
        tally_and_finish();
    end
endmodule : crs_core_test

/* File: crs_mem_model.sv */
module crs_mem_model (
    input  wire logic        i_mclk,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_we,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata
);
    logic [7:0] stk [64];
    // vector bytes echo their address low byte so each handler is distinct
    always_ff @(posedge i_mclk)
    begin
        if (i_we)
            stk[i_addr[5:0]] <= i_wdata;
        if (i_rd)
            o_rdata <= (i_addr[15:8] == 8'h00) ? stk[i_addr[5:0]] : i_addr[7:0];
        else
            o_rdata <= ~o_rdata; // never leave stale data between reads
    end
endmodule : crs_mem_model

/* File: crs_params.svh */
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

// stack pointer: six live bits, fixed upper address bits
`define CRS_SP_BITS   6
`define CRS_SP_RST    6'h3f
`define CRS_SP_UPPER  10'h003

// context sizes in stack bytes
`define CRS_CALL_BYTES 3'h2
`define CRS_INT_BYTES  3'h5

// condition code byte: upper three bits read as ones
`define CRS_CC_UPPER  3'h7

// vector table, high byte at the even address
`define CRS_VEC_RST   16'h0ffe
`define CRS_VEC_TRAP  16'h0ffc
`define CRS_VEC_EXT   16'h0ffa
`define CRS_VEC_MFT   16'h0ff8
`define CRS_VEC_T16   16'h0ff6

// hardware sources, index 0 has the highest vector
`define CRS_NUM_SRC   3

`endif

/* File: crs_pkg.sv */
package crs_pkg;

    typedef enum logic [4:0] {
        OP_NOP   = 5'h00,
        OP_FETCH = 5'h01,
        OP_LDA   = 5'h02,
        OP_LDX   = 5'h03,
        OP_ADD   = 5'h04,
        OP_ADC   = 5'h05,
        OP_SUB   = 5'h06,
        OP_AND   = 5'h07,
        OP_ORA   = 5'h08,
        OP_EOR   = 5'h09,
        OP_INC   = 5'h0a,
        OP_MINUS_ONE = 5'h0b,
        OP_LSL   = 5'h0c,
        OP_LSR   = 5'h0d,
        OP_ROL   = 5'h0e,
        OP_ROR   = 5'h0f,
        OP_BTST  = 5'h10,
        OP_CLEAR_MASK = 5'h11,
        OP_SET_MASK   = 5'h12,
        OP_CLC   = 5'h13,
        OP_SEC   = 5'h14,
        OP_RESET_SP   = 5'h15,
        OP_JMP   = 5'h16,
        OP_JSR   = 5'h17,
        OP_RTS   = 5'h18,
        OP_RETURN_HANDLER = 5'h19,
        OP_SOFTWARE_TRAP  = 5'h1a,
        OP_WAIT  = 5'h1b
    } crs_op_t;

    typedef enum logic [1:0] {
        IDX_NONE  = 2'h0,
        IDX_OFF8  = 2'h1,
        IDX_OFF16 = 2'h2,
        IDX_UNUSED = 2'h3
    } crs_idx_t;

    typedef enum logic [2:0] {
        ST_RUN  = 3'h0,
        ST_PUSH = 3'h1,
        ST_VEC  = 3'h2,
        ST_PULL = 3'h3,
        ST_WAIT = 3'h4
    } crs_st_t;

    typedef enum logic [2:0] {
        K_INT  = 3'h0,
        K_TRAP = 3'h1,
        K_JSR  = 3'h2,
        K_RTS  = 3'h3,
        K_RTI  = 3'h4,
        K_RST  = 3'h5
    } crs_kind_t;

    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } crs_cc_t;

    typedef struct packed {
        logic [7:0] res;
        logic       wr_a;
        logic       wr_x;
        logic       wr_h;
        logic       wr_n;
        logic       wr_z;
        logic       wr_c;
        logic       h;
        logic       n;
        logic       z;
        logic       c;
    } crs_alu_t;

    typedef struct packed {
        crs_st_t    fsm;
        crs_kind_t  kind;
        logic [2:0] cnt;
        logic [7:0] a;
        logic [7:0] x;
        logic [5:0] sp;
        logic [15:0] pc;
        logic [15:0] tgt;
        logic [15:0] ea;
        logic [15:0] vec;
        logic [2:0] srcsel;
        crs_cc_t    cc;
        logic [15:0] maddr;
        logic [7:0] mwdata;
        logic       mwe;
        logic       mrd;
        logic       ready;
        logic       done;
        logic [2:0] ack;
        logic [1:0] rsync;
    } crs_core_t;

endpackage : crs_pkg
